// ===== pm_event_defines.svh
// Offsets, field positions, reset values and timing counts of the PM block
`ifndef PM_EVENT_DEFINES_SVH
`define PM_EVENT_DEFINES_SVH

// Offsets from the programmable block base in system I/O space
`define PM_OFS_ENABLE_LOW       16'h0002
`define PM_OFS_ENABLE_HIGH      16'h0003
`define PM_OFS_CONTROL_LOW      16'h0004
`define PM_OFS_CONTROL_HIGH     16'h0005
`define PM_OFS_GENERAL_STATUS   16'h0008

// Field positions
`define PM_BIT_BUTTON_EN        0
`define PM_BIT_ALARM_EN         2
`define PM_BIT_SCI_GATE         0
`define PM_BIT_OVERRIDE_EN      1
`define PM_BIT_SLEEP_TYPE_LO    2
`define PM_BIT_SLEEP_TRIGGER    5
`define PM_BIT_DEVICE_FLAG      0

// Reset value of every register and the sleep type that powers off
`define PM_REG_RESET            8'h00
`define PM_SLEEP_TYPE_OFF       3'h0

// Override hold time and system clock rate (4 s, 200 MHz)
`define PM_OVERRIDE_TIME_S      32'h0000_0004
`define PM_CLK_FREQ_HZ          32'h0BEB_C200

`endif

// ===== pm_event_pkg.sv
// Types shared by the PM event and control register block
package pm_event_pkg;

   // One-hot sleep sequencer, counting slow-clock rising edges
   typedef enum logic [2:0] {
      SEQ_IDLE   = 3'b001,
      SEQ_FIRST  = 3'b010,
      SEQ_SECOND = 3'b100
   } sleep_seq_t;

   typedef struct packed {
      logic        button_event_enable;
      logic        alarm_event_enable;
      logic        global_sci_gate;
      logic        button_override_enable;
      logic [2:0]  sleep_type_field;
      logic        button_event_flag;
      logic        alarm_event_flag;
      logic        device_event_flag;
      logic        button_prev;
      logic        alarm_prev;
      logic        slow_clk_prev;
      sleep_seq_t  seq;
      logic        power_on;
      logic [31:0] hold_cnt;
      logic        hold_done;
      logic [7:0]  rdata;
      logic        hit;
      logic        sci;
      logic        smi_pulse;
      logic        sleep_write_pulse;
      logic        override_pulse;
   } pm_state_t;

endpackage

// ===== pm_event_regs.sv
// PM enable, control and general event status registers with sleep control
`timescale 1ns/1ps
`include "pm_event_defines.svh"
module pm_event_regs #(
   parameter logic [31:0] OVERRIDE_HOLD_CYCLES =
      `PM_OVERRIDE_TIME_S * `PM_CLK_FREQ_HZ
) (
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        arst_n_in,
   // System I/O access
   input  wire logic [15:0] io_addr_in,
   input  wire logic        io_wr_in,
   input  wire logic        io_rd_in,
   input  wire logic [7:0]  io_wdata_in,
   output logic      [7:0]  io_rdata_out,
   output logic             io_hit_out,
   // Configuration from neighbouring registers
   input  wire logic [15:0] pm_block_base_in,
   input  wire logic        sleep_to_smi_select_in,
   input  wire logic        device_event_sci_enable_in,
   // Event sources
   input  wire logic        button_in,
   input  wire logic        rtc_alarm_in,
   input  wire logic        rtc_32k_in,
   input  wire logic        pme_event_pending_in,
   // Flag clears from the neighbouring status register
   input  wire logic        button_flag_clear_in,
   input  wire logic        alarm_flag_clear_in,
   // Event outputs
   output logic             sci_out,
   output logic             smi_request_out,
   output logic             sleep_write_smi_flag_set_out,
   output logic             button_override_flag_set_out,
   output logic             button_event_flag_out,
   output logic             alarm_event_flag_out,
   // Open-drain power-on request
   output logic             power_on_request_n_out,
   output logic             power_on_request_n_oe_out
);

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------

   function automatic logic reg_hit(input logic [15:0] addr,
                                    input logic [15:0] base,
                                    input logic [15:0] ofs);
      logic [15:0] target;
      target = base + ofs;
      reg_hit = (addr == target);
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------

   logic [2:0] pins_sync;

   pm_sync2 #(
      .WIDTH (3)
   ) u_sync (
      .sys_clk_in (sys_clk_in),
      .arst_n_in  (arst_n_in),
      .async_in   ({rtc_32k_in, rtc_alarm_in, button_in}),
      .sync_out   (pins_sync)
   );

   logic button_s;
   logic alarm_s;
   logic slow_clk_s;

   assign button_s   = pins_sync[0];
   assign alarm_s    = pins_sync[1];
   assign slow_clk_s = pins_sync[2];

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------

   pm_event_pkg::pm_state_t state_r;
   pm_event_pkg::pm_state_t state_nxt;

   logic hit_en_low;
   logic hit_en_high;
   logic hit_ctl_low;
   logic hit_ctl_high;
   logic hit_status;
   logic any_hit;
   logic wr_ctl_high;
   logic trigger_write;
   logic button_rise;
   logic alarm_rise;
   logic slow_rise;
   logic override_fire;
   logic sleep_release;
   logic [7:0] rd_val;

   always_comb begin
      hit_en_low   = reg_hit(io_addr_in, pm_block_base_in,
                             `PM_OFS_ENABLE_LOW);
      hit_en_high  = reg_hit(io_addr_in, pm_block_base_in,
                             `PM_OFS_ENABLE_HIGH);
      hit_ctl_low  = reg_hit(io_addr_in, pm_block_base_in,
                             `PM_OFS_CONTROL_LOW);
      hit_ctl_high = reg_hit(io_addr_in, pm_block_base_in,
                             `PM_OFS_CONTROL_HIGH);
      hit_status   = reg_hit(io_addr_in, pm_block_base_in,
                             `PM_OFS_GENERAL_STATUS);
      any_hit      = hit_en_low | hit_en_high | hit_ctl_low |
                     hit_ctl_high | hit_status;
      wr_ctl_high  = io_wr_in & hit_ctl_high;
      // trigger acts on a written one only
      trigger_write = wr_ctl_high &
                      io_wdata_in[`PM_BIT_SLEEP_TRIGGER];
      button_rise  = button_s & ~state_r.button_prev;
      alarm_rise   = alarm_s & ~state_r.alarm_prev;
      slow_rise    = slow_clk_s & ~state_r.slow_clk_prev;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------

   always_comb begin
      state_nxt = state_r;
      state_nxt.button_prev   = button_s;
      state_nxt.alarm_prev    = alarm_s;
      state_nxt.slow_clk_prev = slow_clk_s;
      state_nxt.smi_pulse         = 1'b0;
      state_nxt.sleep_write_pulse = 1'b0;
      state_nxt.override_pulse    = 1'b0;
      override_fire = 1'b0;
      sleep_release = 1'b0;

      // Register writes; reserved bits are simply not stored
      if (io_wr_in && hit_en_high) begin
         state_nxt.button_event_enable =
            io_wdata_in[`PM_BIT_BUTTON_EN];
         state_nxt.alarm_event_enable =
            io_wdata_in[`PM_BIT_ALARM_EN];
      end else if (io_wr_in && hit_ctl_low) begin
         state_nxt.global_sci_gate = io_wdata_in[`PM_BIT_SCI_GATE];
      end else if (wr_ctl_high) begin
         state_nxt.button_override_enable =
            io_wdata_in[`PM_BIT_OVERRIDE_EN];
         state_nxt.sleep_type_field =
            io_wdata_in[`PM_BIT_SLEEP_TYPE_LO +: 3];
      end

      // sleep-write flag set on every trigger of one
      if (trigger_write) begin
         state_nxt.sleep_write_pulse = 1'b1;
      end

      // SMI instead of sleep when selected
      if (trigger_write && sleep_to_smi_select_in) begin
         state_nxt.smi_pulse = 1'b1;
      end else if (trigger_write &&
                   io_wdata_in[`PM_BIT_SLEEP_TYPE_LO +: 3] ==
                   `PM_SLEEP_TYPE_OFF &&
                   state_r.seq == pm_event_pkg::SEQ_IDLE) begin
         // type 000 starts the power-off sequence
         // any other type falls through with no action
         state_nxt.seq = pm_event_pkg::SEQ_FIRST;
      end

      // second slow edge bounds delay to one..two periods
      case (state_r.seq)
         pm_event_pkg::SEQ_IDLE: begin
         end
         pm_event_pkg::SEQ_FIRST: begin
            if (slow_rise) begin
               state_nxt.seq = pm_event_pkg::SEQ_SECOND;
            end
         end
         pm_event_pkg::SEQ_SECOND: begin
            if (slow_rise) begin
               state_nxt.seq = pm_event_pkg::SEQ_IDLE;
               sleep_release = 1'b1;
            end
         end
         default: begin
            state_nxt.seq = pm_event_pkg::SEQ_IDLE;
         end
      endcase

      // override hold counter, only while machine is on
      if (button_s && state_r.button_override_enable &&
          state_r.power_on && !state_r.hold_done) begin
         if (state_r.hold_cnt == OVERRIDE_HOLD_CYCLES) begin
            override_fire = 1'b1;
            state_nxt.hold_done = 1'b1;
         end else begin
            state_nxt.hold_cnt = state_r.hold_cnt + 32'h0000_0001;
         end
      end else if (!button_s) begin
         state_nxt.hold_cnt  = 32'h0000_0000;
         state_nxt.hold_done = 1'b0;
      end

      // Power-on request; a press while off wakes the machine
      if (override_fire || sleep_release) begin
         state_nxt.power_on = 1'b0;
      end else if (!state_r.power_on && button_rise) begin
         state_nxt.power_on = 1'b1;
      end

      // button flag, set wins over software clear
      if (button_flag_clear_in) begin
         state_nxt.button_event_flag = 1'b0;
      end
      if (button_rise) begin
         state_nxt.button_event_flag = 1'b1;
      end
      // override clears button flag, sets override flag
      if (override_fire) begin
         state_nxt.button_event_flag = 1'b0;
         state_nxt.override_pulse    = 1'b1;
      end

      // alarm flag on every alarm edge, set wins
      if (alarm_flag_clear_in) begin
         state_nxt.alarm_event_flag = 1'b0;
      end
      if (alarm_rise) begin
         state_nxt.alarm_event_flag = 1'b1;
      end

      // write-one clear blocked while events pend
      // write zero ignored, only hardware sets
      if (io_wr_in && hit_status &&
          io_wdata_in[`PM_BIT_DEVICE_FLAG] && !pme_event_pending_in) begin
         state_nxt.device_event_flag = 1'b0;
      end
      // hardware sets device flag on pending events
      if (pme_event_pending_in) begin
         state_nxt.device_event_flag = 1'b1;
      end

      // device flag needs its own enable
      state_nxt.sci = state_nxt.global_sci_gate &
         ((state_nxt.button_event_flag & state_nxt.button_event_enable) |
          (state_nxt.alarm_event_flag & state_nxt.alarm_event_enable) |
          (state_nxt.device_event_flag & device_event_sci_enable_in));

      // Read path, registered; unmapped reads return zero
      rd_val = 8'h00;
      if (hit_en_low) begin
         rd_val = 8'h00;
      end else if (hit_en_high) begin
         rd_val[`PM_BIT_BUTTON_EN] = state_r.button_event_enable;
         rd_val[`PM_BIT_ALARM_EN]  = state_r.alarm_event_enable;
      end else if (hit_ctl_low) begin
         rd_val[`PM_BIT_SCI_GATE] = state_r.global_sci_gate;
      end else if (hit_ctl_high) begin
         rd_val[`PM_BIT_OVERRIDE_EN] = state_r.button_override_enable;
         rd_val[`PM_BIT_SLEEP_TYPE_LO +: 3] = state_r.sleep_type_field;
      end else if (hit_status) begin
         rd_val[`PM_BIT_DEVICE_FLAG] = state_r.device_event_flag;
      end
      if (io_rd_in) begin
         state_nxt.rdata = rd_val;
      end
      state_nxt.hit = (io_rd_in | io_wr_in) & any_hit;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------

   // everything clears to zero except seq, which loads SEQ_IDLE, and power_on, which loads one; machine stays powered
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r <= '{
            button_event_enable:    1'b0,
            alarm_event_enable:     1'b0,
            global_sci_gate:        1'b0,
            button_override_enable: 1'b0,
            sleep_type_field:       3'h0,
            button_event_flag:      1'b0,
            alarm_event_flag:       1'b0,
            device_event_flag:      1'b0,
            button_prev:            1'b0,
            alarm_prev:             1'b0,
            slow_clk_prev:          1'b0,
            seq:                    pm_event_pkg::SEQ_IDLE,
            power_on:               1'b1,
            hold_cnt:               32'h0000_0000,
            hold_done:              1'b0,
            rdata:                  8'h00,
            hit:                    1'b0,
            sci:                    1'b0,
            smi_pulse:              1'b0,
            sleep_write_pulse:      1'b0,
            override_pulse:         1'b0
         };
      end else begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------

   assign io_rdata_out                 = state_r.rdata;
   assign io_hit_out                   = state_r.hit;
   assign sci_out                      = state_r.sci;
   assign smi_request_out              = state_r.smi_pulse;
   assign sleep_write_smi_flag_set_out = state_r.sleep_write_pulse;
   assign button_override_flag_set_out = state_r.override_pulse;
   assign button_event_flag_out        = state_r.button_event_flag;
   assign alarm_event_flag_out         = state_r.alarm_event_flag;

   // Open drain: pulls low to request power, floats for off
   assign power_on_request_n_out    = 1'b0;
   assign power_on_request_n_oe_out = state_r.power_on;

endmodule

// ===== pm_event_regs_assertions.sv
// Port checker for the PM event register block
`timescale 1ns/1ps
module pm_event_regs_checker #(
   parameter logic [31:0] OVERRIDE_HOLD_CYCLES = 32'h2FAF_0800
) (
   // Clock, reset, access
   input wire logic        sys_clk_in,
   input wire logic        arst_n_in,
   input wire logic [15:0] io_addr_in,
   input wire logic        io_wr_in,
   input wire logic        io_rd_in,
   input wire logic [7:0]  io_wdata_in,
   input wire logic [7:0]  io_rdata_out,
   // Configuration and events
   input wire logic [15:0] pm_block_base_in,
   input wire logic        sleep_to_smi_select_in,
   input wire logic        device_event_sci_enable_in,
   input wire logic        button_in,
   input wire logic        sci_out,
   input wire logic        smi_request_out,
   input wire logic        sleep_write_smi_flag_set_out,
   input wire logic        button_override_flag_set_out,
   input wire logic        button_event_flag_out,
   input wire logic        power_on_request_n_oe_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   // --------------------------------
   // Shadow of written enables
   // --------------------------------
   logic [15:0] ofs;
   logic        trig, gate_r, en0_r, en2_r;
   logic [31:0] held_r;
   assign ofs = io_addr_in - pm_block_base_in;
   assign trig = io_wr_in && ofs == 16'h0005 && io_wdata_in[5];
   // Raw pin count runs ahead of the synced count in the block
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         gate_r <= 1'b0;
         en0_r  <= 1'b0;
         en2_r  <= 1'b0;
         held_r <= 32'h0000_0000;
      end else begin
         if (io_wr_in && ofs == 16'h0004) gate_r <= io_wdata_in[0];
         if (io_wr_in && ofs == 16'h0003) en0_r <= io_wdata_in[0];
         if (io_wr_in && ofs == 16'h0003) en2_r <= io_wdata_in[2];
         held_r <= button_in ? held_r + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   // --------------------------------
   // Assertions
   // --------------------------------
   a_low_rsvd: assert property (
      io_rd_in && ofs == 16'h0002 |=> io_rdata_out == 8'h00)
      else $error("enable low not zero");
   a_en_rsvd: assert property (
      io_rd_in && ofs == 16'h0003 |=> (io_rdata_out & 8'hFA) == 8'h00)
      else $error("enable high reserved set");
   a_ctl_rsvd: assert property (
      io_rd_in && ofs == 16'h0005 |=> (io_rdata_out & 8'hE1) == 8'h00)
      else $error("control high reserved set");
   a_sts_rsvd: assert property (
      io_rd_in && ofs == 16'h0008 |=> (io_rdata_out & 8'hFE) == 8'h00)
      else $error("status reserved set");
   a_trig_flag: assert property (
      trig |=> sleep_write_smi_flag_set_out)
      else $error("no sleep write pulse");
   a_smi_route: assert property (
      trig && sleep_to_smi_select_in |-> ##[1:2] smi_request_out)
      else $error("no smi pulse");
   a_ovr_effect: assert property (
      button_override_flag_set_out |-> ##[0:1]
      (!button_event_flag_out && !power_on_request_n_oe_out))
      else $error("override effect missing");
   a_ovr_hold: assert property (
      button_override_flag_set_out |-> held_r >= OVERRIDE_HOLD_CYCLES)
      else $error("override too early");
   a_gate_off: assert property (
      !gate_r && !$past(gate_r) |-> !sci_out)
      else $error("sci with gate clear");
   a_btn_sci: assert property (
      gate_r && $past(gate_r) && en0_r && $past(en0_r) &&
      button_event_flag_out |-> sci_out)
      else $error("button sci missing");
   a_no_enable: assert property (
      !en0_r && !$past(en0_r) && !en2_r && !$past(en2_r) &&
      !device_event_sci_enable_in &&
      !$past(device_event_sci_enable_in) |-> !sci_out)
      else $error("sci without enable");
   c_sleep: cover property (trig ##1 sleep_write_smi_flag_set_out);
   c_override: cover property (button_override_flag_set_out);
   c_sci: cover property ($rose(sci_out));
endmodule

bind pm_event_regs pm_event_regs_checker #(
   .OVERRIDE_HOLD_CYCLES(OVERRIDE_HOLD_CYCLES)
) u_checker (
   .sys_clk_in, .arst_n_in, .io_addr_in, .io_wr_in, .io_rd_in,
   .io_wdata_in, .io_rdata_out, .pm_block_base_in,
   .sleep_to_smi_select_in, .device_event_sci_enable_in, .button_in,
   .sci_out, .smi_request_out, .sleep_write_smi_flag_set_out,
   .button_override_flag_set_out, .button_event_flag_out,
   .power_on_request_n_oe_out
);

// ===== pm_switch_model.sv
// Power switch, alarm line and free-running 32 kHz clock model
`timescale 1ns/1ps
module pm_switch_model #(
   parameter int SLOW_HALF_NS = 15625
) (
   // From the bench and the block
   input  wire logic press_in,
   input  wire logic alarm_in,
   input  wire logic req_n_in,
   input  wire logic req_n_oe_in,
   // To the block and the bench
   output logic      button_out,
   output logic      alarm_out,
   output logic      rtc_32k_out,
   output logic      pin_level_out
);
   assign button_out = press_in;
   assign alarm_out = alarm_in;
   // Released pin is pulled up, so off reads high
   assign pin_level_out = req_n_oe_in ? req_n_in : 1'b1;
   // Odd offset keeps slow edges away from system edges
   initial begin
      rtc_32k_out = 1'b0;
      #3;
      forever #(SLOW_HALF_NS) rtc_32k_out = ~rtc_32k_out;
   end
endmodule

// ===== pm_sync2.sv
// Two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module pm_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             arst_n_in,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

// ===== tb_pm_event_regs.sv
// Bench of the PM event register block
`timescale 1ns/1ps
`define CHK(n, e, g) \
   begin \
      compares++; \
      if ((g) !== (e)) begin \
         fails++; \
         $display("[ERR] %s exp %0h got %0h", n, e, g); \
      end \
   end
module tb_pm_event_regs;
   localparam int HOLD = 20;
   localparam int SLOW = 80;
   localparam logic [15:0] BASE = 16'h0400;
   localparam logic [3:0] OFS [5] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
   logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, sel = 1'b0;
   logic dev_en = 1'b0, pend = 1'b0, bclr = 1'b0, aclr = 1'b0;
   logic press = 1'b0, alarm = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic hit, sci, smi, slp, ovr, bflag, aflag;
   logic req_n, oe, button, alarm_pin, rtc, pin;
   int fails = 0;
   int compares = 0;
   int n;

   // HOLD matches the override count handed to the block
   pm_event_regs #(.OVERRIDE_HOLD_CYCLES(32'h0000_0014)) dut (
      .sys_clk_in(clk), .arst_n_in(arst_n), .io_addr_in(addr),
      .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata),
      .io_rdata_out(rdata), .io_hit_out(hit), .pm_block_base_in(BASE),
      .sleep_to_smi_select_in(sel), .device_event_sci_enable_in(dev_en),
      .button_in(button), .rtc_alarm_in(alarm_pin), .rtc_32k_in(rtc),
      .pme_event_pending_in(pend), .button_flag_clear_in(bclr),
      .alarm_flag_clear_in(aclr), .sci_out(sci), .smi_request_out(smi),
      .sleep_write_smi_flag_set_out(slp),
      .button_override_flag_set_out(ovr), .button_event_flag_out(bflag),
      .alarm_event_flag_out(aflag), .power_on_request_n_out(req_n),
      .power_on_request_n_oe_out(oe)
   );
   pm_switch_model #(.SLOW_HALF_NS(200)) u_switch (
      .press_in(press), .alarm_in(alarm), .req_n_in(req_n),
      .req_n_oe_in(oe), .button_out(button), .alarm_out(alarm_pin),
      .rtc_32k_out(rtc), .pin_level_out(pin)
   );
   initial forever #2.5 clk = ~clk;

   task automatic final_report;
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Idle edge first, so strobes never toggle twice in one step
   task automatic acc(input logic w, input logic [3:0] o,
                      input logic [7:0] d);
      cyc(1);
      addr = BASE + {12'h000, o};
      wr = w;
      rd = ~w;
      wdata = d;
      cyc(1);
      wr = 1'b0;
      rd = 1'b0;
   endtask
   task automatic rchk(input logic [3:0] o, input logic [7:0] e);
      acc(1'b0, o, 8'h00);
      `CHK("rdata", e, rdata)
   endtask
   task automatic tap(input int k);
      press = 1'b1;
      cyc(k);
      press = 1'b0;
      cyc(3);
   endtask
   task automatic clr(input logic b);
      bclr = b;
      aclr = ~b;
      cyc(1);
      bclr = 1'b0;
      aclr = 1'b0;
   endtask
   task automatic t_regs;
      foreach (OFS[i]) rchk(OFS[i], 8'h00);
      rchk(4'h6, 8'h00);
      `CHK("hit", 1'b0, hit)
      acc(1'b1, 4'h3, 8'h05);
      acc(1'b1, 4'h4, 8'h01);
      acc(1'b1, 4'h5, 8'h1E);
      rchk(4'h2, 8'h00);
      `CHK("hit", 1'b1, hit)
      rchk(4'h3, 8'h05);
      rchk(4'h4, 8'h01);
      rchk(4'h5, 8'h1E);
   endtask
   task automatic t_type_nop;
      acc(1'b1, 4'h5, 8'h3C);
      `CHK("slp", 1'b1, slp)
      rchk(4'h5, 8'h1C);
      acc(1'b1, 4'h5, 8'h1C);
      `CHK("slp", 1'b0, slp)
      cyc(3 * SLOW);
      `CHK("oe", 1'b1, oe)
      `CHK("pin", 1'b0, pin)
   endtask
   task automatic t_sleep;
      acc(1'b1, 4'h5, 8'h20);
      `CHK("slp", 1'b1, slp)
      n = 0;
      while (oe === 1'b1 && n < 3 * SLOW) begin
         cyc(1);
         n++;
      end
      `CHK("pin", 1'b1, pin)
      `CHK("dly_lo", 1'b1, n >= SLOW - 3)
      `CHK("dly_hi", 1'b1, n <= 2 * SLOW + 5)
      tap(4);
   endtask
   task automatic t_smi;
      sel = 1'b1;
      acc(1'b1, 4'h5, 8'h20);
      n = (smi === 1'b1);
      cyc(1);
      `CHK("smi", 1'b1, n + (smi === 1'b1) == 1)
      cyc(3 * SLOW);
      `CHK("oe", 1'b1, oe)
      sel = 1'b0;
   endtask
   task automatic t_button;
      acc(1'b1, 4'h3, 8'h00);
      clr(1'b1);
      tap(4);
      `CHK("bflag", 1'b1, bflag)
      `CHK("sci", 1'b0, sci)
      acc(1'b1, 4'h3, 8'h01);
      `CHK("sci", 1'b1, sci)
      acc(1'b1, 4'h4, 8'h00);
      `CHK("sci", 1'b0, sci)
      acc(1'b1, 4'h4, 8'h01);
      clr(1'b1);
      `CHK("sci", 1'b0, sci)
   endtask
   task automatic t_alarm;
      acc(1'b1, 4'h3, 8'h04);
      repeat (2) begin
         alarm = 1'b1;
         cyc(4);
         alarm = 1'b0;
         `CHK("aflag", 1'b1, aflag)
         `CHK("sci", 1'b1, sci)
         clr(1'b0);
      end
      acc(1'b1, 4'h3, 8'h00);
      alarm = 1'b1;
      cyc(4);
      alarm = 1'b0;
      `CHK("sci", 1'b0, sci)
      clr(1'b0);
   endtask
   task automatic t_dev;
      pend = 1'b1;
      rchk(4'h8, 8'h01);
      `CHK("sci", 1'b0, sci)
      dev_en = 1'b1;
      cyc(1);
      `CHK("sci", 1'b1, sci)
      acc(1'b1, 4'h8, 8'h01);
      pend = 1'b0;
      rchk(4'h8, 8'h01);
      acc(1'b1, 4'h8, 8'h00);
      rchk(4'h8, 8'h01);
      acc(1'b1, 4'h8, 8'h01);
      rchk(4'h8, 8'h00);
      dev_en = 1'b0;
   endtask
   task automatic t_override;
      acc(1'b1, 4'h5, 8'h02);
      tap(HOLD - 2);
      `CHK("oe", 1'b1, oe)
      press = 1'b1;
      n = 0;
      while (ovr !== 1'b1 && n < HOLD + 10) begin
         cyc(1);
         n++;
      end
      `CHK("ovr", 1'b1, ovr === 1'b1 && n >= HOLD)
      cyc(1);
      `CHK("bflag", 1'b0, bflag)
      `CHK("oe", 1'b0, oe)
      press = 1'b0;
      cyc(3);
      tap(4);
   endtask
   // Mid-run reset must clear live state, leave power on
   task automatic t_reset;
      acc(1'b1, 4'h3, 8'h05);
      `CHK("sci", 1'b1, sci)
      arst_n = 1'b0;
      cyc(2);
      `CHK("oe", 1'b1, oe)
      arst_n = 1'b1;
      foreach (OFS[i]) rchk(OFS[i], 8'h00);
      `CHK("bflag", 1'b0, bflag)
      `CHK("sci", 1'b0, sci)
   endtask

   initial begin
      repeat (2) @(posedge clk);
      #1;
      arst_n = 1'b1;
      cyc(3);
      t_regs;
      t_type_nop;
      t_sleep;
      t_smi;
      t_button;
      t_alarm;
      t_dev;
      t_override;
      t_reset;
      final_report;
   end
   initial begin
      #100_000;
      fails++;
      final_report;
   end
endmodule
